// >>> verilog/fscp_params.svh
`ifndef FSCP_PARAMS_SVH
`define FSCP_PARAMS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define FSCP_CMD_REG_WRITE    8'h01
`define FSCP_CMD_PAGE_PROG    8'h02
`define FSCP_CMD_WRITE_DIS    8'h04
`define FSCP_CMD_READ_STATUS  8'h05
`define FSCP_CMD_WRITE_EN     8'h06
`define FSCP_CMD_READ_CONFIG  8'h15
`define FSCP_CMD_SECTOR_ERASE 8'h20
`define FSCP_CMD_HALF_ERASE   8'h52
`define FSCP_CMD_CHIP_ERASE_A 8'h60
`define FSCP_CMD_CHIP_ERASE_B 8'hC7
`define FSCP_CMD_BLOCK_ERASE  8'hD8
`define FSCP_CMD_ENTER_WIDE   8'hB7
`define FSCP_CMD_EXIT_WIDE    8'hE9

// ----------------------------------------------------------------
// reset values and frame lengths
// ----------------------------------------------------------------
`define FSCP_STATUS_RST       8'h00
`define FSCP_CONFIG_RST       8'h07
`define FSCP_CMD_BITS         6'd8
`define FSCP_WR_SHORT_BITS    6'd16
`define FSCP_WR_LONG_BITS     6'd24
`define FSCP_ADDR3_BITS       6'd32
`define FSCP_CAPTURE_BITS     6'd40
`define FSCP_CNT_MAX          6'd63

// ----------------------------------------------------------------
// dummy clocks per code 00,01,10,11
// ----------------------------------------------------------------
`define FSCP_DUMMY_STD        16'hA868
`define FSCP_DUMMY_DUAL_IO    16'hA864
`define FSCP_DUMMY_QUAD_IO    16'hA846

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FSCP_CLK_MHZ          50
`define FSCP_REG_WRITE_NS     10000
`define FSCP_REG_WRITE_CYC \
    ((`FSCP_REG_WRITE_NS * `FSCP_CLK_MHZ + 999) / 1000)

`endif

// >>> verilog/fscp_pkg.sv
package fscp_pkg;

    // status word, bit7 down to bit0
    typedef struct packed {
        logic       status_write_lock;
        logic       quad_lines_enable;
        logic [3:0] protect_level;
        logic       write_enable_latch;
        logic       write_busy_flag;
    } fscp_status_s;

    // configuration word, bit7 down to bit0
    typedef struct packed {
        logic [1:0] dummy_count_select;
        logic       wide_address_flag;
        logic       preamble_output_enable;
        logic       protect_origin_select;
        logic [2:0] drive_strength_field;
    } fscp_config_s;

    // dummy clock counts per read family
    typedef struct packed {
        logic [3:0] single_dual_quad_out;
        logic [3:0] dual_io;
        logic [3:0] quad_io;
    } fscp_dummy_s;

    typedef enum logic [1:0] {
        FSCP_IDLE,
        FSCP_CHECK,
        FSCP_REG_WRITE,
        FSCP_ARRAY
    } fscp_state_e;

endpackage

// >>> verilog/fscp_regs.sv
`timescale 1ns/1ns
`include "fscp_params.svh"
// Notes on behaviour
// - protect level bits plus outside area decode block program and erases
// - chip erase runs only with all four protect level bits zero
// - protect level bits reset to zero, memory unprotected
// - quad enable frees protect and reset pins, disables pin locking
// - lock bit set and protect pin low refuses register writes
// - only raising the protect pin, quad mode or reset leaves pin locked protection
// - status write lock bit resets to zero
// - status word: lock, quad, levels 3..0, latch, busy; low two volatile
// - drive strength resets to 111; codes 000 and 100 reserved
// - origin select bit3 is one-time settable, zero means top
// - bit4 enables preamble during dummy clocks, resets to zero
// - bit5 wide address set by enter, cleared by exit or reset
// - dummy select gives per read family dummy clock counts
// - register write refused while write enable latch is clear
// - register write leaves latch and busy untouched by its data
// - register write only with exactly 8 or 16 data bits
// - self-timed write at chip select rise, busy set, then cleared
// - unlocked or pin high allows register writes after write enable
// - busy reads 1 during operations; latch gates their acceptance
module fscp_regs
    import fscp_pkg::*;
#(
    parameter int REG_WRITE_CYCLES = `FSCP_REG_WRITE_CYC
) (
    // system side
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // serial link
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  si,
    output logic                       so,
    output logic                       so_oe,
    // protect and mode pins
    input  wire logic                  write_protect_pin,
    input  wire logic                  qpi_active,
    output logic                       pin_functions_enable,
    // array engine and outside area decoder
    output logic                       array_op_start,
    output logic [7:0]                 array_op_cmd,
    output logic [31:0]                array_op_addr,
    input  wire logic                  array_protect_hit,
    input  wire logic                  array_op_done,
    // register contents
    output fscp_pkg::fscp_status_s     flash_status_word,
    output fscp_pkg::fscp_config_s     flash_config_word,
    output fscp_pkg::fscp_dummy_s      dummy_clocks
);
    import fscp_pkg::*;

    localparam int TW_W = $clog2(REG_WRITE_CYCLES + 1);

    // ----------------------------------------------------------------
    // link domain: frame capture
    // ----------------------------------------------------------------
    // fresh is set while deselected so each frame restarts its count;
    // count and captured bytes survive the chip select rise because
    // the link clock stops, and the system side reads them afterwards
    logic        fresh;
    logic [5:0]  bit_cnt;
    logic [7:0]  cmd_q;
    logic [31:0] data_q;
    logic        frame_tgl;
    logic        so_q;
    logic [15:0] snap;

    wire  [5:0]  next_bit_cnt = fresh ? 6'd1 :
                               (bit_cnt == `FSCP_CNT_MAX) ? bit_cnt :
                               bit_cnt + 6'd1;
    wire         shift_cmd    = fresh || (bit_cnt < `FSCP_CMD_BITS);
    wire         shift_data   = !fresh && (bit_cnt >= `FSCP_CMD_BITS) &&
                                (bit_cnt < `FSCP_CAPTURE_BITS);
    wire         is_rd_status = (cmd_q == `FSCP_CMD_READ_STATUS);
    wire         is_rd_config = (cmd_q == `FSCP_CMD_READ_CONFIG);
    wire         rd_active    = !fresh && (bit_cnt >= `FSCP_CMD_BITS) &&
                                (is_rd_status || is_rd_config);
    wire  [7:0]  rd_byte      = is_rd_status ? snap[15:8] : snap[7:0];
    wire  [2:0]  rd_index     = 3'd7 - bit_cnt[2:0];

    // reset sets it too, so the first frame never counts from unknown
    always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
        if (rst) begin
            fresh <= 1'b1;
        end else if (cs_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            bit_cnt   <= 6'd0;
            cmd_q     <= 8'h00;
            data_q    <= 32'h0000_0000;
            frame_tgl <= 1'b0;
        end else begin
            bit_cnt   <= next_bit_cnt;
            frame_tgl <= frame_tgl ^ fresh;
            if (shift_cmd) begin
                cmd_q <= {cmd_q[6:0], si};
            end
            if (shift_data) begin
                data_q <= {data_q[30:0], si};
            end
        end
    end

    // status stays readable while busy; the word repeats every 8 clocks until the count saturates at 63, then bit0 holds
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            so_q <= 1'b0;
        end else begin
            so_q <= rd_byte[rd_index];
        end
    end

    assign so    = so_q;
    assign so_oe = rd_active && !cs_n;

    // ----------------------------------------------------------------
    // system domain: synchronisers
    // ----------------------------------------------------------------
    logic cs_s1, cs_s2, cs_d;
    logic tgl_s1, tgl_s2, tgl_seen;
    logic wp_s1, wp_s2;
    logic qpi_s1, qpi_s2;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cs_s1  <= 1'b1;
            cs_s2  <= 1'b1;
            cs_d   <= 1'b1;
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            wp_s1  <= 1'b1;
            wp_s2  <= 1'b1;
            qpi_s1 <= 1'b0;
            qpi_s2 <= 1'b0;
        end else begin
            cs_s1  <= cs_n;
            cs_s2  <= cs_s1;
            cs_d   <= cs_s2;
            tgl_s1 <= frame_tgl;
            tgl_s2 <= tgl_s1;
            wp_s1  <= write_protect_pin;
            wp_s2  <= wp_s1;
            qpi_s1 <= qpi_active;
            qpi_s2 <= qpi_s1;
        end
    end

    wire cs_rise   = cs_s2 && !cs_d;
    wire cs_fall   = !cs_s2 && cs_d;
    // a frame with no clocks leaves the toggle alone and is ignored
    wire frame_end = cs_rise && (tgl_s2 != tgl_seen);

    // ----------------------------------------------------------------
    // system domain: decode
    // ----------------------------------------------------------------
    fscp_status_s stat;
    fscp_config_s cfg;
    fscp_state_e  st;
    logic [TW_W-1:0] tw_cnt;

    wire [7:0] fcmd     = cmd_q;
    wire [5:0] fbits    = bit_cnt;
    wire       quad_on  = stat.quad_lines_enable || qpi_s2;
    wire       pin_lock = stat.status_write_lock && !wp_s2 &&
                          !quad_on;
    wire       len_ok   = (fbits == `FSCP_WR_SHORT_BITS) ||
                          (fbits == `FSCP_WR_LONG_BITS);
    wire       has_cfg  = (fbits == `FSCP_WR_LONG_BITS);
    wire [7:0] wr_stat  = has_cfg ? data_q[15:8] : data_q[7:0];
    wire [7:0] wr_cfg   = data_q[7:0];
    wire       c_write_enable_cmd   = (fcmd == `FSCP_CMD_WRITE_EN) &&
                          (fbits == `FSCP_CMD_BITS);
    wire       c_wrdi   = (fcmd == `FSCP_CMD_WRITE_DIS) &&
                          (fbits == `FSCP_CMD_BITS);
    wire       c_enter  = (fcmd == `FSCP_CMD_ENTER_WIDE);
    wire       c_exit   = (fcmd == `FSCP_CMD_EXIT_WIDE);
    wire       c_register_write_cmd   = (fcmd == `FSCP_CMD_REG_WRITE);
    wire       c_chip   = (fcmd == `FSCP_CMD_CHIP_ERASE_A) ||
                          (fcmd == `FSCP_CMD_CHIP_ERASE_B);
    wire       c_area   = (fcmd == `FSCP_CMD_PAGE_PROG) ||
                          (fcmd == `FSCP_CMD_SECTOR_ERASE) ||
                          (fcmd == `FSCP_CMD_HALF_ERASE) ||
                          (fcmd == `FSCP_CMD_BLOCK_ERASE);
    wire       register_write_cmd_ok  = c_register_write_cmd && stat.write_enable_latch &&
                          !pin_lock && len_ok;
    wire       array_ok = (c_chip || c_area) &&
                          stat.write_enable_latch;
    wire [31:0] faddr   = cfg.wide_address_flag ? data_q :
                          (fbits >= `FSCP_CAPTURE_BITS) ?
                          {8'h00, data_q[31:8]} :
                          {8'h00, data_q[23:0]};
    wire       take     = frame_end && (st == FSCP_IDLE);
    wire       tw_done  = (tw_cnt == TW_W'(REG_WRITE_CYCLES - 1));
    wire       prot_rej = c_chip ? (stat.protect_level != 4'h0) :
                          array_protect_hit;

    // ----------------------------------------------------------------
    // system domain: state and registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stat           <= fscp_status_s'(`FSCP_STATUS_RST);
            cfg            <= fscp_config_s'(`FSCP_CONFIG_RST);
            st             <= FSCP_IDLE;
            tw_cnt         <= '0;
            tgl_seen       <= 1'b0;
            array_op_start <= 1'b0;
            array_op_cmd   <= 8'h00;
            array_op_addr  <= 32'h0000_0000;
        end else begin
            array_op_start <= 1'b0;
            if (frame_end) begin
                tgl_seen <= tgl_s2;
            end
            unique case (st)
                FSCP_IDLE: begin
                    if (take && c_write_enable_cmd) begin
                        stat.write_enable_latch <= 1'b1;
                    end
                    if (take && c_wrdi) begin
                        stat.write_enable_latch <= 1'b0;
                    end
                    if (take && c_enter) begin
                        cfg.wide_address_flag <= 1'b1;
                    end
                    if (take && c_exit) begin
                        cfg.wide_address_flag <= 1'b0;
                    end
                    if (take && register_write_cmd_ok) begin
                        // latch and busy bits of the data are dropped
                        stat.status_write_lock <= wr_stat[7];
                        stat.quad_lines_enable <= wr_stat[6];
                        stat.protect_level     <= wr_stat[5:2];
                        stat.write_busy_flag   <= 1'b1;
                        tw_cnt                 <= '0;
                        st                     <= FSCP_REG_WRITE;
                        if (has_cfg) begin
                            cfg.dummy_count_select     <= wr_cfg[7:6];
                            cfg.preamble_output_enable <= wr_cfg[4];
                            cfg.drive_strength_field   <= wr_cfg[2:0];
                            // one-time bit: a write can set it, never clear it; only reset clears it
                            cfg.protect_origin_select  <=
                                cfg.protect_origin_select | wr_cfg[3];
                        end
                    end
                    if (take && array_ok) begin
                        array_op_cmd  <= fcmd;
                        array_op_addr <= faddr;
                        st            <= FSCP_CHECK;
                    end
                end
                FSCP_CHECK: begin
                    // decoder answers on the registered command and address
                    if (prot_rej) begin
                        st <= FSCP_IDLE;
                    end else begin
                        array_op_start       <= 1'b1;
                        stat.write_busy_flag <= 1'b1;
                        st                   <= FSCP_ARRAY;
                    end
                end
                FSCP_REG_WRITE: begin
                    tw_cnt <= tw_cnt + TW_W'(1);
                    if (tw_done) begin
                        stat.write_busy_flag    <= 1'b0;
                        stat.write_enable_latch <= 1'b0;
                        st                      <= FSCP_IDLE;
                    end
                end
                FSCP_ARRAY: begin
                    if (array_op_done) begin
                        stat.write_busy_flag    <= 1'b0;
                        stat.write_enable_latch <= 1'b0;
                        st                      <= FSCP_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // snapshot for status reads, and derived outputs
    // ----------------------------------------------------------------
    wire [3:0]  dc_shift = {cfg.dummy_count_select, 2'b00};
    wire [15:0] dc_std   = `FSCP_DUMMY_STD >> dc_shift;
    wire [15:0] dc_dual  = `FSCP_DUMMY_DUAL_IO >> dc_shift;
    wire [15:0] dc_quad  = `FSCP_DUMMY_QUAD_IO >> dc_shift;

    // snapshot is taken at select and stays still for the frame, so the
    // link side reads a settled word; limitation: busy seen by a read
    // is the value at its select, so polling re-selects
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            snap                 <= {`FSCP_STATUS_RST, `FSCP_CONFIG_RST};
            dummy_clocks         <= '0;
            pin_functions_enable <= 1'b1;
        end else begin
            if (cs_fall) begin
                snap <= {stat, cfg};
            end
            dummy_clocks.single_dual_quad_out <= dc_std[3:0];
            dummy_clocks.dual_io              <= dc_dual[3:0];
            dummy_clocks.quad_io              <= dc_quad[3:0];
            pin_functions_enable <= !quad_on;
        end
    end

    assign flash_status_word = stat;
    assign flash_config_word = cfg;

endmodule

// >>> bench/fscp_regs_props.sv
`timescale 1ns/1ns
`include "fscp_params.svh"
module fscp_regs_props
    import fscp_pkg::*;
#(
    parameter int REG_WRITE_CYCLES = 8
) (
    // clock and reset
    input wire logic                   clk_sys,
    input wire logic                   rst,
    // pins and array engine
    input wire logic                   write_protect_pin,
    input wire logic                   qpi_active,
    input wire logic                   pin_functions_enable,
    input wire logic                   array_op_start,
    input wire logic [7:0]             array_op_cmd,
    input wire logic                   array_protect_hit,
    // register contents
    input wire fscp_pkg::fscp_status_s flash_status_word,
    input wire fscp_pkg::fscp_config_s flash_config_word,
    input wire fscp_pkg::fscp_dummy_s  dummy_clocks
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    wire busy = flash_status_word.write_busy_flag;
    wire latch = flash_status_word.write_enable_latch;
    wire quad = flash_status_word.quad_lines_enable;
    wire lock = flash_status_word.status_write_lock;

    function automatic logic [11:0] dc_exp(input logic [1:0] s);
        case (s)
            2'b01: dc_exp = 12'h664;
            2'b10: dc_exp = 12'h888;
            2'b11: dc_exp = 12'hAAA;
            default: dc_exp = 12'h846;
        endcase
    endfunction

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    // only four cycles held, so any timed write of four or more cycles fits
    property p_busy_hold;
        $rose(busy) && !array_op_start |-> busy [*4];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped early");
    property p_busy_end;
        $fell(busy) |-> !latch;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("latch kept after busy");
    property p_chip;
        array_op_start && (array_op_cmd inside {`FSCP_CMD_CHIP_ERASE_A,
            `FSCP_CMD_CHIP_ERASE_B}) |-> flash_status_word[5:2] == 4'h0;
    endproperty
    a_chip: assert property (p_chip)
        else $error("chip erase with levels set");
    property p_area;
        array_op_start && (array_op_cmd inside {`FSCP_CMD_PAGE_PROG,
            `FSCP_CMD_SECTOR_ERASE, `FSCP_CMD_HALF_ERASE,
            `FSCP_CMD_BLOCK_ERASE}) |-> !$past(array_protect_hit);
    endproperty
    a_area: assert property (p_area)
        else $error("protected area op started");
    property p_gate;
        array_op_start |-> $past(latch) && busy;
    endproperty
    a_gate: assert property (p_gate)
        else $error("op without latch or busy");
    property p_lock;
        (lock && !write_protect_pin && !qpi_active &&
            pin_functions_enable) [*4]
            |=> $stable(flash_status_word[7:2]);
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked bits changed");
    property p_pins;
        (!quad && !qpi_active) [*5] |-> pin_functions_enable;
    endproperty
    a_pins: assert property (p_pins)
        else $error("pin functions off");
    property p_dummy;
        !$past(rst) |-> dummy_clocks ==
            dc_exp($past(flash_config_word.dummy_count_select));
    endproperty
    a_dummy: assert property (p_dummy)
        else $error("dummy counts wrong");
endmodule

bind fscp_regs fscp_regs_props #(.REG_WRITE_CYCLES(REG_WRITE_CYCLES)) u_props (
    .clk_sys, .rst, .write_protect_pin, .qpi_active, .pin_functions_enable,
    .array_op_start, .array_op_cmd, .array_protect_hit, .flash_status_word,
    .flash_config_word, .dummy_clocks
);

// >>> bench/fscp_host_model.sv
`timescale 1ns/1ns
module fscp_host_model (
    // link pins
    output logic     sclk,
    output logic     cs_n,
    output logic     si,
    input wire logic so
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
    end

    // mode 0 frame, msb first; bits 8..15 of so come back in rd
    task automatic frame(input logic [31:0] b, input int n,
                         output logic [7:0] rd);
        rd = 8'h00;
        cs_n = 1'b0;
        #80;
        for (int i = 0; i < n; i++) begin
            si = b[31-i];
            #7 sclk = 1'b1;
            if (i >= 8 && i < 16) rd = {rd[6:0], so};
            #8 sclk = 1'b0;
        end
        #20 cs_n = 1'b1;
        // released line must not keep a usable level
        si = ~si;
        #200;
    endtask
endmodule

// >>> bench/flash_status_config_protect_tb.sv
`timescale 1ns/1ns
`include "fscp_params.svh"
module flash_status_config_protect_tb;
    import fscp_pkg::*;

    logic         clk_sys;
    logic         rst;
    logic         write_protect_pin;
    logic         qpi_active;
    logic         array_protect_hit;
    logic         array_op_done;
    logic         sclk;
    logic         cs_n;
    logic         si;
    logic         so;
    logic         so_oe;
    logic         pin_functions_enable;
    logic         array_op_start;
    logic [7:0]   array_op_cmd;
    logic [31:0]  array_op_addr;
    fscp_status_s flash_status_word;
    fscp_config_s flash_config_word;
    fscp_dummy_s  dummy_clocks;
    logic [7:0]   rd;
    int           bad_count = 0;
    int           n_checks = 0;
    int           n_start = 0;
    int           n_oe = 0;

    fscp_regs #(.REG_WRITE_CYCLES(40)) DUT (
        .clk_sys, .rst, .sclk, .cs_n, .si, .so, .so_oe, .write_protect_pin,
        .qpi_active, .pin_functions_enable, .array_op_start, .array_op_cmd,
        .array_op_addr, .array_protect_hit, .array_op_done,
        .flash_status_word, .flash_config_word, .dummy_clocks
    );
    fscp_host_model u_host (.sclk, .cs_n, .si, .so);

    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (array_op_start === 1'b1) begin
            n_start <= n_start + 1;
        end
    end
    // read frames drive so only after the command byte
    always @(posedge sclk) begin
        if (so_oe === 1'b1) begin
            n_oe <= n_oe + 1;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (flash_status_word.write_busy_flag !== 1'b0 && k < 200) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 200) begin
            bad_count++;
            finish_test();
        end
    endtask

    task automatic cmd(input logic [31:0] b, input int n);
        u_host.frame(b, n, rd);
        wait_idle();
    endtask

    task automatic write_enable_cmd();
        cmd({`FSCP_CMD_WRITE_EN, 24'h0}, 8);
    endtask

    task automatic op_done();
        @(posedge clk_sys);
        array_op_done <= 1'b1;
        @(posedge clk_sys);
        array_op_done <= 1'b0;
        wait_idle();
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        write_protect_pin = 1'b1;
        qpi_active = 1'b0;
        array_protect_hit = 1'b0;
        array_op_done = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({4'h0, flash_status_word}, 12'h000);
        check({4'h0, flash_config_word}, 12'h007);
        check(dummy_clocks, 12'h846);
        $display("reset test done");
        cmd({`FSCP_CMD_REG_WRITE, 8'h3F, 8'hFD, 8'h00}, 24);
        check({4'h0, flash_status_word}, 12'h000);
        write_enable_cmd();
        cmd({`FSCP_CMD_REG_WRITE, 8'h3F, 8'hF0, 8'h00}, 20);
        check({6'h0, flash_status_word[7:2]}, 12'h000);
        $display("refusal test done");
        write_enable_cmd();
        u_host.frame({`FSCP_CMD_REG_WRITE, 8'h3F, 8'hFD, 8'h00}, 24, rd);
        check({11'h0, flash_status_word.write_busy_flag}, 12'h001);
        wait_idle();
        check({4'h0, flash_status_word}, 12'h03C);
        check({4'h0, flash_config_word}, 12'h0DD);
        check(dummy_clocks, 12'hAAA);
        $display("write test done");
        write_enable_cmd();
        cmd({`FSCP_CMD_CHIP_ERASE_A, 24'h0}, 8);
        cmd({`FSCP_CMD_CHIP_ERASE_B, 24'h0}, 8);
        check(n_start[11:0], 12'h000);
        u_host.frame({`FSCP_CMD_READ_STATUS, 24'h0}, 16, rd);
        check({4'h0, rd}, 12'h03E);
        check(n_oe[11:0], 12'h008);
        $display("erase refusal test done");
        cmd({`FSCP_CMD_REG_WRITE, 8'h80, 16'h0}, 16);
        check({4'h0, flash_status_word}, 12'h080);
        @(posedge clk_sys);
        write_protect_pin <= 1'b0;
        write_enable_cmd();
        cmd({`FSCP_CMD_REG_WRITE, 8'h00, 16'h0}, 16);
        check({6'h0, flash_status_word[7:2]}, 12'h020);
        @(posedge clk_sys);
        write_protect_pin <= 1'b1;
        write_enable_cmd();
        cmd({`FSCP_CMD_REG_WRITE, 8'h00, 16'h0}, 16);
        check({4'h0, flash_status_word}, 12'h000);
        $display("pin lock test done");
        @(posedge clk_sys);
        array_protect_hit <= 1'b1;
        write_enable_cmd();
        cmd({`FSCP_CMD_PAGE_PROG, 24'h00_1000}, 32);
        check(n_start[11:0], 12'h000);
        @(posedge clk_sys);
        array_protect_hit <= 1'b0;
        u_host.frame({`FSCP_CMD_PAGE_PROG, 24'h00_1000}, 32, rd);
        check({11'h0, flash_status_word.write_busy_flag}, 12'h001);
        check(n_start[11:0], 12'h001);
        check({4'h0, array_op_cmd}, {4'h0, `FSCP_CMD_PAGE_PROG});
        check(array_op_addr[23:12], 12'h001);
        op_done();
        check({4'h0, flash_status_word}, 12'h000);
        write_enable_cmd();
        u_host.frame({`FSCP_CMD_CHIP_ERASE_B, 24'h0}, 8, rd);
        check(n_start[11:0], 12'h002);
        check({4'h0, array_op_cmd}, {4'h0, `FSCP_CMD_CHIP_ERASE_B});
        op_done();
        check({4'h0, flash_status_word}, 12'h000);
        $display("array test done");
        cmd({`FSCP_CMD_ENTER_WIDE, 24'h0}, 8);
        check({11'h0, flash_config_word.wide_address_flag}, 12'h001);
        cmd({`FSCP_CMD_EXIT_WIDE, 24'h0}, 8);
        check({11'h0, flash_config_word.wide_address_flag}, 12'h000);
        write_enable_cmd();
        cmd({`FSCP_CMD_REG_WRITE, 8'h40, 8'h01, 8'h00}, 24);
        check({11'h0, pin_functions_enable}, 12'h000);
        check({4'h0, flash_status_word}, 12'h040);
        check({4'h0, flash_config_word}, 12'h009);
        check(dummy_clocks, 12'h846);
        $display("mode test done");
        finish_test();
    end
endmodule
